// ---- include/mcs_map.vh ----
`ifndef MCS_MAP_VH
`define MCS_MAP_VH
// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define MCS_CLK_MHZ          100
`define MCS_T_OFF_US         10
`define MCS_T_ON_MS          2
`define MCS_T_INIT_MS        300
`define MCS_T_INT_ON_MS      200
`define MCS_T_INT_OFF_US     500
`define MCS_T_PDN_US         100
`define MCS_T_NR_MS          1
`define MCS_T_RST_MIN_US     10
`define MCS_T_LOS_US         100
// Cycle counts derived from the times
`define MCS_CYC_OFF          (`MCS_T_OFF_US * `MCS_CLK_MHZ)
`define MCS_CYC_ON           (`MCS_T_ON_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_CYC_INIT         (`MCS_T_INIT_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_CYC_INT_ON       (`MCS_T_INT_ON_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_CYC_INT_OFF      (`MCS_T_INT_OFF_US * `MCS_CLK_MHZ)
`define MCS_CYC_PDN          (`MCS_T_PDN_US * `MCS_CLK_MHZ)
`define MCS_CYC_NR           (`MCS_T_NR_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_CYC_RST_MIN      (`MCS_T_RST_MIN_US * `MCS_CLK_MHZ)
`define MCS_CYC_LOS          (`MCS_T_LOS_US * `MCS_CLK_MHZ)
// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define MCS_ADDR_CTRL        12'h000
`define MCS_ADDR_STATUS      12'h004
`define MCS_ADDR_IRQ_STAT    12'h008
`define MCS_ADDR_IRQ_MASK    12'h00c
`define MCS_ADDR_FLAGS       12'h010
// Control bits
`define MCS_CTRL_FAULT_BIT   0
`define MCS_CTRL_RESET_VAL   32'h00000000
// Status bits
`define MCS_ST_TXON_BIT      0
`define MCS_ST_NR_BIT        1
`define MCS_ST_LOS_BIT       2
`define MCS_ST_PDN_BIT       3
`define MCS_ST_INIT_BIT      4
// Irq bits: module flags and bus events share one layout
`define MCS_IRQ_W            4
`define MCS_IRQ_LOS_BIT      0
`define MCS_IRQ_NR_BIT       1
`define MCS_IRQ_TXOFF_BIT    2
`define MCS_IRQ_RDY_BIT      3
`define MCS_MASK_RESET_VAL   4'h0
`endif

// ---- design/mcs_delay_timer.v ----
`timescale 1ns/1ps
`include "mcs_map.vh"
// Follows an input level; output changes once the input has held a new
// level for LIMIT cycles, which bounds the response at LIMIT edges.
module mcs_delay_timer #(
    parameter W     = 32,
    parameter LIMIT = 1000
) (
    clk_sys,
    sys_rst,
    level_in,
    level_out
);
    input  wire         clk_sys;
    input  wire         sys_rst;
    input  wire         level_in;
    output reg          level_out;

    reg  [W-1:0]        cnt_ff;
    localparam [W-1:0]  LIM = LIMIT;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_ff    <= {W{1'b0}};
            level_out <= 1'b0;
        end
        else if (level_in == level_out)
            cnt_ff <= {W{1'b0}};
        else if (cnt_ff >= LIM - 1'b1)
        begin
            cnt_ff    <= {W{1'b0}};
            level_out <= level_in;
        end
        else
            cnt_ff <= cnt_ff + 1'b1;
    end
endmodule // mcs_delay_timer

// ---- design/mcs_cycle_counter.v ----
`timescale 1ns/1ps
// Counts up while run is high, clears otherwise; done when LIMIT reached.
module mcs_cycle_counter #(
    parameter W     = 32,
    parameter LIMIT = 1000
) (
    clk_sys,
    sys_rst,
    run,
    done
);
    input  wire         clk_sys;
    input  wire         sys_rst;
    input  wire         run;
    output reg          done;

    reg  [W-1:0]        cnt_ff;
    localparam [W-1:0]  LIM = LIMIT;

    always @(posedge clk_sys)
    begin
        if (sys_rst || !run)
        begin
            cnt_ff <= {W{1'b0}};
            done   <= 1'b0;
        end
        else if (cnt_ff >= LIM - 1'b1)
            done <= 1'b1;
        else
            cnt_ff <= cnt_ff + 1'b1;
    end
endmodule // mcs_cycle_counter

// ---- design/mcs_control_io.v ----
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mcs_map.vh"
// What this block does
// [R1] Laser off within 10 us of off-request
// [R2] Laser back on within 2 ms
// [R3] Initialisation done within 300 ms
// [R4] Interrupt asserted within 200 ms of condition
// [R5] Flags clear on read; interrupt drops within 500us
// [R6] Power-down entered within 100 us
// [R7] Not-ready asserted within 1 ms of fault
// [R8] Not-ready negated within 1 ms of clearance
// [R9] Reset only after 10 us power-down pulse
// [R10] Signal-lost asserted within 100 us
// [R11] Signal-lost negated within 100 us
// [R12] Flags latch until read; interrupt follows them
module mcs_control_io #(
    parameter CYC_OFF     = `MCS_CYC_OFF,
    parameter CYC_ON      = `MCS_CYC_ON,
    parameter CYC_INIT    = `MCS_CYC_INIT,
    parameter CYC_PDN     = `MCS_CYC_PDN,
    parameter CYC_NR      = `MCS_CYC_NR,
    parameter CYC_RST_MIN = `MCS_CYC_RST_MIN,
    parameter CYC_LOS     = `MCS_CYC_LOS
) (
    clk_sys,
    sys_rst,
    tx_off_request,
    pdown_reset,
    rx_signal_lost_raw,
    internal_fault,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    laser_enable,
    power_down,
    module_not_ready,
    module_interrupt,
    rx_signal_lost,
    irq
);
    input  wire         clk_sys;
    input  wire         sys_rst;
    input  wire         tx_off_request;
    input  wire         pdown_reset;
    input  wire         rx_signal_lost_raw;
    input  wire         internal_fault;
    input  wire         psel;
    input  wire         penable;
    input  wire         pwrite;
    input  wire [11:0]  paddr;
    input  wire [31:0]  pwdata;
    output reg  [31:0]  prdata;
    output reg          pready;
    output reg          pslverr;
    output reg          laser_enable;
    output reg          power_down;
    output reg          module_not_ready;
    output reg          module_interrupt;
    output reg          rx_signal_lost;
    output reg          irq;

    // ----------------------------------------------------------------
    // State machine for power-down and initialisation
    // ----------------------------------------------------------------
    localparam [1:0]    ST_INIT = 2'h0;
    localparam [1:0]    ST_RUN  = 2'h1;
    localparam [1:0]    ST_PDN  = 2'h2;

    localparam          NW      = `MCS_IRQ_W;

    reg  [1:0]          state_ff;
    reg  [1:0]          nxt_state;
    reg  [31:0]         ctrl_ff;
    reg  [NW-1:0]       flags_ff;
    reg  [NW-1:0]       nxt_flags;
    reg  [NW-1:0]       istat_ff;
    reg  [NW-1:0]       nxt_istat;
    reg  [NW-1:0]       imask_ff;
    reg                 los_prev_ff;
    reg                 nr_prev_ff;
    reg                 txoff_prev_ff;
    reg                 rdy_prev_ff;

    wire                pd_long;
    wire                init_done;
    wire                laser_off_done;
    wire                laser_on_done;
    wire                los_filt;
    wire                nr_filt;
    wire                fault_any;
    wire                running;
    wire                acc;
    wire                wr;
    wire                rd;
    wire [NW-1:0]       flag_evt;
    wire [NW-1:0]       istat_evt;

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // Power-down/reset input must stand this long before it counts
    mcs_cycle_counter #(.W(32), .LIMIT(CYC_RST_MIN)) u_pd_min (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (pdown_reset),
        .done    (pd_long)
    ); // R9

    mcs_cycle_counter #(.W(32), .LIMIT(CYC_INIT)) u_init (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (state_ff == ST_INIT),
        .done    (init_done)
    ); // R3

    // Laser turns off quickly, back on after settling
    mcs_cycle_counter #(.W(32), .LIMIT(CYC_OFF)) u_off (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (tx_off_request),
        .done    (laser_off_done)
    ); // R1

    mcs_cycle_counter #(.W(32), .LIMIT(CYC_ON)) u_on (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (!tx_off_request && running),
        .done    (laser_on_done)
    ); // R2

    mcs_delay_timer #(.W(32), .LIMIT(CYC_LOS)) u_los (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .level_in  (rx_signal_lost_raw),
        .level_out (los_filt)
    ); // R10 R11

    assign fault_any = internal_fault | ctrl_ff[`MCS_CTRL_FAULT_BIT];

    mcs_delay_timer #(.W(32), .LIMIT(CYC_NR)) u_nr (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .level_in  (fault_any),
        .level_out (nr_filt)
    ); // R7 R8

    assign running = (state_ff == ST_RUN);

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_INIT:
                if (pd_long)
                    nxt_state = ST_PDN;
                else if (init_done)
                    nxt_state = ST_RUN; // R3
            ST_RUN:
                if (pd_long)
                    nxt_state = ST_PDN; // R6 R9
            ST_PDN:
                if (!pdown_reset)
                    nxt_state = ST_INIT; // R3
            default:
                nxt_state = ST_INIT;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
            state_ff <= ST_INIT;
        else
            state_ff <= nxt_state;
    end

    // ----------------------------------------------------------------
    // Module outputs
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            laser_enable     <= 1'b0;
            power_down       <= 1'b0;
            module_not_ready <= 1'b1;
            rx_signal_lost   <= 1'b1;
        end
        else
        begin
            // Off the moment the request stands, well inside the limit
            if (tx_off_request || laser_off_done || !running)
                laser_enable <= 1'b0; // R1
            else if (laser_on_done || laser_enable)
                laser_enable <= 1'b1; // R2
            power_down       <= (nxt_state == ST_PDN); // R6
            module_not_ready <= nr_filt || !running; // R7 R8
            rx_signal_lost   <= los_filt; // R10 R11
        end
    end

    // ----------------------------------------------------------------
    // Module flags, clear on read, and the module interrupt
    // ----------------------------------------------------------------
    assign flag_evt[`MCS_IRQ_LOS_BIT]   = los_filt & ~los_prev_ff;
    assign flag_evt[`MCS_IRQ_NR_BIT]    = nr_filt & ~nr_prev_ff;
    assign flag_evt[`MCS_IRQ_TXOFF_BIT] = tx_off_request & ~txoff_prev_ff;
    assign flag_evt[`MCS_IRQ_RDY_BIT]   = running & ~rdy_prev_ff;
    assign istat_evt = flag_evt;

    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;

    always @*
    begin
        nxt_flags = flags_ff;
        if (rd && paddr == `MCS_ADDR_FLAGS)
            nxt_flags = {NW{1'b0}}; // R5
        nxt_flags = nxt_flags | flag_evt; // R12
        nxt_istat = istat_ff;
        if (wr && paddr == `MCS_ADDR_IRQ_STAT)
            nxt_istat = istat_ff & ~pwdata[NW-1:0];
        nxt_istat = nxt_istat | istat_evt;
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            flags_ff         <= {NW{1'b0}};
            istat_ff         <= {NW{1'b0}};
            los_prev_ff      <= 1'b0;
            nr_prev_ff       <= 1'b0;
            txoff_prev_ff    <= 1'b0;
            rdy_prev_ff      <= 1'b0;
            module_interrupt <= 1'b0;
            irq              <= 1'b0;
        end
        else
        begin
            flags_ff         <= nxt_flags;
            istat_ff         <= nxt_istat;
            los_prev_ff      <= los_filt;
            nr_prev_ff       <= nr_filt;
            txoff_prev_ff    <= tx_off_request;
            rdy_prev_ff      <= running;
            module_interrupt <= |nxt_flags; // R4 R5 R12
            irq              <= |(nxt_istat & imask_ff);
        end
    end

    // ----------------------------------------------------------------
    // APB slave: one wait-free access phase
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_ff  <= `MCS_CTRL_RESET_VAL;
            imask_ff <= `MCS_MASK_RESET_VAL;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h00000000;
                case (paddr)
                    `MCS_ADDR_CTRL:
                        prdata <= {31'h0, ctrl_ff[0]};
                    `MCS_ADDR_STATUS:
                        prdata <= {27'h0, state_ff == ST_INIT, power_down,
                                   rx_signal_lost, module_not_ready, laser_enable};
                    `MCS_ADDR_IRQ_STAT:
                        prdata <= {28'h0, istat_ff};
                    `MCS_ADDR_IRQ_MASK:
                        prdata <= {28'h0, imask_ff};
                    `MCS_ADDR_FLAGS:
                        prdata <= {28'h0, flags_ff};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
            if (wr && paddr == `MCS_ADDR_CTRL)
                ctrl_ff <= {31'h0, pwdata[0]};
            if (wr && paddr == `MCS_ADDR_IRQ_MASK)
                imask_ff <= pwdata[NW-1:0];
        end
    end
endmodule // mcs_control_io

// ---- verification/mcs_host_pins.sv ----
`timescale 1ns/1ps
// ------
// Host side of the module control pins
// ------
module mcs_host_pins (
    input  wire logic       clk_sys,
    input  wire logic       off_cmd,
    input  wire logic       los_cmd,
    input  wire logic       flt_cmd,
    input  wire logic       pdn_go,
    input  wire logic [7:0] pdn_len,
    output logic            tx_off_request = 1'b0,
    output logic            rx_signal_lost_raw = 1'b0,
    output logic            internal_fault = 1'b0,
    output wire logic       pdown_reset
);
    logic [7:0] pdn_left_ff = 8'h00;

    // Pulse length is whatever the bench asks for, short ones included
    assign pdown_reset = (pdn_left_ff != 8'h00);

    always @(posedge clk_sys)
    begin
        tx_off_request     <= off_cmd;
        rx_signal_lost_raw <= los_cmd;
        internal_fault     <= flt_cmd;
        if (pdn_go)
            pdn_left_ff <= pdn_len;
        else if (pdn_left_ff != 8'h00)
            pdn_left_ff <= pdn_left_ff - 8'h01;
    end
endmodule // mcs_host_pins

// ---- verification/mcs_control_io_monitor.sv ----
`timescale 1ns/1ps
module mcs_control_io_monitor #(
    parameter int CYC_OFF     = 5,
    parameter int CYC_ON      = 20,
    parameter int CYC_INIT    = 40,
    parameter int CYC_NR      = 10,
    parameter int CYC_RST_MIN = 10,
    parameter int CYC_LOS     = 10
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        tx_off_request,
    input wire logic        pdown_reset,
    input wire logic        rx_signal_lost_raw,
    input wire logic        internal_fault,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        laser_enable,
    input wire logic        power_down,
    input wire logic        module_not_ready,
    input wire logic        module_interrupt,
    input wire logic        rx_signal_lost
);
    localparam int ON_MAX   = CYC_ON + 3;
    localparam int INIT_MAX = CYC_INIT + 4;
    localparam int PDN_MIN  = CYC_RST_MIN + 3;
    localparam int NR_MIN   = CYC_NR + 3;
    localparam int LOS_MIN  = CYC_LOS + 3;
    logic [7:0] pdn_cnt_ff;
    logic [7:0] flt_cnt_ff;
    logic [7:0] lhi_cnt_ff;
    logic [7:0] llo_cnt_ff;

    function automatic logic [7:0] bump(input logic on, input logic [7:0] v);
        if (!on)
            return 8'h00;
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // ------
    // Cycles pdown_reset and internal_fault have been high, and rx_signal_lost_raw has held its level
    // ------
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pdn_cnt_ff <= 8'h00;
            flt_cnt_ff <= 8'h00;
            lhi_cnt_ff <= 8'h00;
            llo_cnt_ff <= 8'h00;
        end
        else
        begin
            pdn_cnt_ff <= bump(pdown_reset, pdn_cnt_ff);
            flt_cnt_ff <= bump(internal_fault, flt_cnt_ff);
            lhi_cnt_ff <= bump(rx_signal_lost_raw, lhi_cnt_ff);
            llo_cnt_ff <= bump(!rx_signal_lost_raw, llo_cnt_ff);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_flags_rd;
        psel && penable && pready && !pwrite && paddr == 12'h010;
    endsequence
    sequence s_ready_back;
        ##[1:INIT_MAX] !module_not_ready;
    endsequence

    property p_tx_off;
        $rose(tx_off_request) |-> ##[1:CYC_OFF] !laser_enable;
    endproperty
    property p_tx_on;
        $fell(tx_off_request) && !module_not_ready && !power_down
            |-> ##[1:ON_MAX] laser_enable;
    endproperty
    property p_init;
        $fell(power_down) |-> s_ready_back;
    endproperty
    property p_int_on;
        $rose(rx_signal_lost) |-> ##[0:2] module_interrupt;
    endproperty
    property p_int_off;
        s_flags_rd |-> ##[1:2] !module_interrupt;
    endproperty
    property p_pdn;
        pdn_cnt_ff >= PDN_MIN |-> power_down;
    endproperty
    property p_rst_min;
        $rose(power_down) |-> pdn_cnt_ff >= CYC_RST_MIN;
    endproperty
    property p_nr_on;
        flt_cnt_ff >= NR_MIN |-> module_not_ready;
    endproperty
    property p_los_on;
        lhi_cnt_ff >= LOS_MIN |-> rx_signal_lost;
    endproperty
    property p_los_off;
        llo_cnt_ff >= LOS_MIN |-> !rx_signal_lost;
    endproperty

    a_tx_off: assert property (p_tx_off)
        else $error("laser still on after off request");
    a_tx_on: assert property (p_tx_on)
        else $error("laser not restored in time");
    a_init: assert property (p_init)
        else $error("initialisation too slow");
    a_int_on: assert property (p_int_on)
        else $error("interrupt late after signal loss");
    a_int_off: assert property (p_int_off)
        else $error("interrupt kept after flag read");
    a_pdn: assert property (p_pdn)
        else $error("power-down not entered");
    a_rst_min: assert property (p_rst_min)
        else $error("power-down on too short a pulse");
    a_nr_on: assert property (p_nr_on)
        else $error("not-ready missing during fault");
    a_los_on: assert property (p_los_on)
        else $error("signal-lost not asserted");
    a_los_off: assert property (p_los_off)
        else $error("signal-lost not negated");
endmodule // mcs_control_io_monitor

// ---- verification/module_control_status_io_tb.sv ----
`timescale 1ns/1ps
`include "mcs_map.vh"
module module_control_status_io_tb;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        off_cmd = 1'b0;
    logic        los_cmd = 1'b0;
    logic        flt_cmd = 1'b0;
    logic        pdn_go = 1'b0;
    logic [7:0]  pdn_len = 8'h00;
    logic [31:0] rd_data;
    logic        rd_err;
    int          err_count = 0;
    int          samples_checked = 0;
    wire         tx_off_request, pdown_reset, rx_signal_lost_raw, internal_fault;
    wire [31:0]  prdata;
    wire         pready, pslverr, laser_enable, power_down;
    wire         module_not_ready, module_interrupt, rx_signal_lost, irq;

    always #5 clk_sys = ~clk_sys;

    mcs_host_pins host (.clk_sys, .off_cmd, .los_cmd, .flt_cmd, .pdn_go, .pdn_len,
        .tx_off_request, .rx_signal_lost_raw, .internal_fault, .pdown_reset);
    mcs_control_io #(.CYC_ON(20), .CYC_INIT(40), .CYC_NR(10),
        .CYC_RST_MIN(10), .CYC_LOS(10)) uut (.clk_sys, .sys_rst, .tx_off_request,
        .pdown_reset, .rx_signal_lost_raw, .internal_fault, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .laser_enable, .power_down,
        .module_not_ready, .module_interrupt, .rx_signal_lost, .irq);

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s exp=%h seen=%h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, then releases and idles a cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rd_data, exp);
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #50000;
        err_count++;
        stop_test();
    end

    initial
    begin
        tick(12);
        sys_rst <= 1'b0;
        tick(44);
        chk("not_ready", module_not_ready, 0);
        tick(24);
        chk("laser", laser_enable, 1);
        rd(`MCS_ADDR_STATUS, 32'h1, "status");
        rd(`MCS_ADDR_CTRL, 32'h0, "ctrl");
        rd(`MCS_ADDR_IRQ_MASK, 32'h0, "mask");
        chk("int_set", module_interrupt, 1);
        chk("irq_masked", irq, 0);
        rd(`MCS_ADDR_FLAGS, 32'h8, "flags_ready");
        chk("int_clr", module_interrupt, 0);
        rd(`MCS_ADDR_IRQ_STAT, 32'h8, "irq_stat");
        apb(1'b1, `MCS_ADDR_IRQ_MASK, 32'hf);
        tick(1);
        chk("irq_on", irq, 1);
        apb(1'b1, `MCS_ADDR_IRQ_STAT, 32'h8);
        chk("irq_off", irq, 0);
        $display("test registers done");
        off_cmd <= 1'b1;
        tick(7);
        chk("laser_off", laser_enable, 0);
        rd(`MCS_ADDR_FLAGS, 32'h4, "flags_txoff");
        off_cmd <= 1'b0;
        tick(25);
        chk("laser_on", laser_enable, 1);
        $display("test laser done");
        los_cmd <= 1'b1;
        tick(15);
        chk("los_on", rx_signal_lost, 1);
        chk("int_los", module_interrupt, 1);
        rd(`MCS_ADDR_FLAGS, 32'h1, "flags_los");
        los_cmd <= 1'b0;
        tick(15);
        chk("los_off", rx_signal_lost, 0);
        $display("test signal loss done");
        flt_cmd <= 1'b1;
        tick(15);
        chk("nr_fault", module_not_ready, 1);
        flt_cmd <= 1'b0;
        tick(15);
        chk("nr_clear", module_not_ready, 0);
        apb(1'b1, `MCS_ADDR_CTRL, 32'h1);
        tick(15);
        chk("nr_forced", module_not_ready, 1);
        rd(`MCS_ADDR_CTRL, 32'h1, "ctrl_back");
        apb(1'b1, `MCS_ADDR_CTRL, 32'h0);
        tick(15);
        chk("nr_unforced", module_not_ready, 0);
        rd(`MCS_ADDR_FLAGS, 32'h2, "flags_fault");
        $display("test fault done");
        tick(25);
        pdn_len <= 8'd8;
        pdn_go <= 1'b1;
        tick(1);
        pdn_go <= 1'b0;
        tick(20);
        chk("pdn_short", power_down, 0);
        pdn_len <= 8'd40;
        pdn_go <= 1'b1;
        tick(1);
        pdn_go <= 1'b0;
        tick(16);
        chk("pdn_long", power_down, 1);
        rd(`MCS_ADDR_STATUS, 32'ha, "status_pdn");
        tick(27);
        chk("pdn_release", power_down, 0);
        chk("nr_init", module_not_ready, 1);
        rd(`MCS_ADDR_STATUS, 32'h12, "status_init");
        tick(41);
        chk("nr_ready", module_not_ready, 0);
        $display("test power-down done");
        rd(12'h020, 32'h0, "unmapped");
        chk("slverr", rd_err, 1);
        $display("test unmapped done");
        stop_test();
    end
endmodule // module_control_status_io_tb

bind mcs_control_io mcs_control_io_monitor #(.CYC_OFF(CYC_OFF), .CYC_ON(CYC_ON),
    .CYC_INIT(CYC_INIT), .CYC_NR(CYC_NR), .CYC_RST_MIN(CYC_RST_MIN), .CYC_LOS(CYC_LOS))
    u_mon (.clk_sys, .sys_rst, .tx_off_request, .pdown_reset, .rx_signal_lost_raw,
    .internal_fault, .psel, .penable, .pwrite, .paddr, .pready, .laser_enable,
    .power_down, .module_not_ready, .module_interrupt, .rx_signal_lost);
